/* File: inc/ccf_pkg.sv */
// shared constants, field layouts and carrier types of the comparator control block
package ccf_pkg;
  localparam int REG_W = 8;
  localparam int NUM_CMP = 2;
  localparam int STAT_W = 4;
  localparam int MV_W = 5;

  // register indices; byte address is four times the index
  localparam logic [7:0] CMP0_CTRL_IDX = 8'h99;
  localparam logic [7:0] CMP1_CTRL_IDX = 8'h9A;
  localparam logic [7:0] CFG_IDX = 8'h9C;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h9D;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h9E;

  // control register fields
  localparam int EN_BIT = 7;
  localparam int RES_BIT = 6;
  localparam int RISE_BIT = 5;
  localparam int FALL_BIT = 4;
  localparam int POS_HI = 3;
  localparam int POS_LO = 2;
  localparam int NEG_HI = 1;
  localparam int NEG_LO = 0;
  localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;

  // configuration register fields
  localparam int CFG_LP0 = 0;
  localparam int CFG_LP1 = 1;
  localparam int CFG_RST0 = 2;
  localparam int CFG_WAKE = 3;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [STAT_W-1:0] STAT_RESET = 4'h0;

  // hysteresis codes and the voltages they select
  localparam logic [1:0] HYST_OFF = 2'h0;
  localparam logic [1:0] HYST_5 = 2'h1;
  localparam logic [1:0] HYST_10 = 2'h2;
  localparam logic [1:0] HYST_20 = 2'h3;
  localparam logic [MV_W-1:0] HYST_OFF_MV = 5'h00;
  localparam logic [MV_W-1:0] HYST_5_MV = 5'h05;
  localparam logic [MV_W-1:0] HYST_10_MV = 5'h0A;
  localparam logic [MV_W-1:0] HYST_20_MV = 5'h14;

  function automatic logic [MV_W-1:0] hyst_mv(input logic [1:0] code);
    unique case (code)
      HYST_OFF: hyst_mv = HYST_OFF_MV;
      HYST_5: hyst_mv = HYST_5_MV;
      HYST_10: hyst_mv = HYST_10_MV;
      HYST_20: hyst_mv = HYST_20_MV;
    endcase
  endfunction

  typedef struct packed {logic on; logic [MV_W-1:0] posMv; logic [MV_W-1:0] negMv;} ccf_ana_s;
  typedef struct packed {logic fall; logic rise;} ccf_evt_s;
  typedef struct packed {
    ccf_ana_s ana; logic [3:0] hyst; logic rise; logic fall; logic res; logic resPrev;
  } ccf_ch_s;
  typedef struct packed {
    logic ack; logic [REG_W-1:0] rdat; logic [3:0] cfg; logic [STAT_W-1:0] stat;
    logic [STAT_W-1:0] mask; logic irq; logic wake; logic rstReq; logic [NUM_CMP-1:0] latch;
  } ccf_top_s;
endpackage

/* File: hdl/ccf_sync.sv */
// two-stage synchroniser for the raw comparator results
`timescale 1ns/1ps
module ccf_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [1:0][W-1:0] st_r, st_nxt;

  always_comb begin
    st_nxt = {st_r[0], din};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r[1];
endmodule // ccf_sync

/* File: hdl/ccf_channel.sv */
// one comparator channel: control byte, result tracking and sticky edge flags
`timescale 1ns/1ps
module ccf_channel (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  input wire logic rawSync,
  output ccf_pkg::ccf_ana_s anaCtl,
  output logic [7:0] ctrlByte,
  output ccf_pkg::ccf_evt_s evt,
  output logic result
);
  ccf_pkg::ccf_ch_s st_r, st_nxt;

  // edge seen between this cycle's result and last cycle's
  assign evt = '{ // RULE16
    fall: ~st_r.res & st_r.resPrev, // RULE3
    rise: st_r.res & ~st_r.resPrev // RULE4
  };

  always_comb begin
    st_nxt = st_r;
    st_nxt.res = rawSync & st_r.ana.on; // RULE6
    st_nxt.resPrev = st_r.res;
    if (wrEn) begin
      st_nxt.ana.on = wrData[ccf_pkg::EN_BIT]; // RULE7
      st_nxt.hyst = wrData[ccf_pkg::POS_HI:ccf_pkg::NEG_LO]; // RULE8
      st_nxt.ana.posMv = ccf_pkg::hyst_mv(wrData[ccf_pkg::POS_HI:ccf_pkg::POS_LO]); // RULE10
      st_nxt.ana.negMv = ccf_pkg::hyst_mv(wrData[ccf_pkg::NEG_HI:ccf_pkg::NEG_LO]); // RULE9
      st_nxt.rise = wrData[ccf_pkg::RISE_BIT];
      st_nxt.fall = wrData[ccf_pkg::FALL_BIT];
    end
    // an edge in the cycle of a clearing write still sets the flag
    st_nxt.rise = st_nxt.rise | evt.rise; // RULE4 RULE5
    st_nxt.fall = st_nxt.fall | evt.fall; // RULE3 RULE5
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign anaCtl = st_r.ana;
  assign result = st_r.res;
  assign ctrlByte = {st_r.ana.on, st_r.res, st_r.rise, st_r.fall, st_r.hyst};
endmodule // ccf_channel

/* File: hdl/ccf_top.sv */
// comparator control and status block with classic wishbone register access
//
// What this block does
// RULE1 - two independent comparators, each with its own control register and settings
// RULE2 - each comparator interrupts on rising, falling or both output edges
// RULE3 - a falling output edge sets the falling flag at control bit 4
// RULE4 - a rising output edge sets the rising flag at control bit 5
// RULE5 - edge flags stay set until software writes zero; hardware never clears
// RULE6 - read-only bit 6 shows the current comparator result
// RULE7 - enable bit 7 turns the comparator on when one, off when zero
// RULE8 - bits 3:2 pick positive hysteresis, bits 1:0 negative hysteresis
// RULE9 - negative hysteresis codes: off, 5 mV, 10 mV, 20 mV
// RULE10 - positive hysteresis uses the same four-level coding, 00 off
// RULE11 - software should clear both flags after enabling or changing mode
// RULE12 - edge interrupts can wake the processor from idle mode
// RULE13 - comparator zero offers an output usable as a reset source
// RULE14 - one latched synchronised output and one unlatched output per comparator
// RULE15 - response time selectable between high-speed and low-power modes
// RULE16 - edges found by comparing synchronised result with its previous value
`timescale 1ns/1ps
module ccf_top #(
  parameter int ADR_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [ccf_pkg::NUM_CMP-1:0] cmpRaw,
  input wire logic idleMode,
  output ccf_pkg::ccf_ana_s ana0,
  output ccf_pkg::ccf_ana_s ana1,
  output logic [ccf_pkg::NUM_CMP-1:0] lowPower,
  output logic [ccf_pkg::NUM_CMP-1:0] latchOut,
  output logic [ccf_pkg::NUM_CMP-1:0] asyncOut,
  output logic irq,
  output logic wakeReq,
  output logic rstReq
);
  ccf_pkg::ccf_top_s st_r, st_nxt;

  logic [ccf_pkg::NUM_CMP-1:0] rawSync;
  logic [ccf_pkg::NUM_CMP-1:0] resVec;
  logic [ccf_pkg::NUM_CMP-1:0] chOn;
  logic [ccf_pkg::NUM_CMP-1:0] wrCtl;
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  ccf_pkg::ccf_evt_s evt0;
  ccf_pkg::ccf_evt_s evt1;
  logic [ccf_pkg::STAT_W-1:0] evtVec;
  logic take;
  logic wrLow;
  logic wrCfg;
  logic wrStat;
  logic wrMask;
  logic [ccf_pkg::REG_W-1:0] rdMux;
  logic pending;

  // byte address of a register index; upper address bits must be zero
  function automatic logic isReg(input logic [ADR_W-1:0] a, input logic [7:0] idx);
    isReg = (a == {{(ADR_W-10){1'b0}}, idx, 2'b00});
  endfunction

  // the analog results are asynchronous to clk
  ccf_sync #(
    .W(ccf_pkg::NUM_CMP)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(cmpRaw),
    .dout(rawSync)
  );

  ccf_channel u_ch0 ( // RULE1
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(wrCtl[0]),
    .wrData(wb_dat_i[7:0]),
    .rawSync(rawSync[0]),
    .anaCtl(ana0),
    .ctrlByte(ctrl0),
    .evt(evt0),
    .result(resVec[0])
  );

  ccf_channel u_ch1 ( // RULE1
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(wrCtl[1]),
    .wrData(wb_dat_i[7:0]),
    .rawSync(rawSync[1]),
    .anaCtl(ana1),
    .ctrlByte(ctrl1),
    .evt(evt1),
    .result(resVec[1])
  );

  assign chOn = {ana1.on, ana0.on};
  assign evtVec = {evt1.fall, evt1.rise, evt0.fall, evt0.rise};

  // bus side: every access is answered one cycle after the strobe
  assign take = wb_cyc_i & wb_stb_i & ~st_r.ack;
  // data lives in the low byte lane only
  assign wrLow = take & wb_we_i & wb_sel_i[0];
  assign wrCtl[0] = wrLow & isReg(wb_adr_i, ccf_pkg::CMP0_CTRL_IDX);
  assign wrCtl[1] = wrLow & isReg(wb_adr_i, ccf_pkg::CMP1_CTRL_IDX);
  assign wrCfg = wrLow & isReg(wb_adr_i, ccf_pkg::CFG_IDX);
  assign wrStat = wrLow & isReg(wb_adr_i, ccf_pkg::IRQ_STAT_IDX);
  assign wrMask = wrLow & isReg(wb_adr_i, ccf_pkg::IRQ_MASK_IDX);

  always_comb begin
    rdMux = '0;
    if (isReg(wb_adr_i, ccf_pkg::CMP0_CTRL_IDX)) begin
      rdMux = ctrl0;
    end else if (isReg(wb_adr_i, ccf_pkg::CMP1_CTRL_IDX)) begin
      rdMux = ctrl1;
    end else if (isReg(wb_adr_i, ccf_pkg::CFG_IDX)) begin
      rdMux = {4'h0, st_r.cfg};
    end else if (isReg(wb_adr_i, ccf_pkg::IRQ_STAT_IDX)) begin
      rdMux = {4'h0, st_r.stat};
    end else if (isReg(wb_adr_i, ccf_pkg::IRQ_MASK_IDX)) begin
      rdMux = {4'h0, st_r.mask};
    end
  end

  assign pending = |(st_r.stat & st_r.mask);

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = take;
    if (take) begin
      // unmapped addresses are acknowledged and read as zero
      st_nxt.rdat = wb_we_i ? st_r.rdat : rdMux;
    end
    if (wrCfg) begin
      st_nxt.cfg = wb_dat_i[3:0]; // RULE15
    end
    if (wrMask) begin
      st_nxt.mask = wb_dat_i[ccf_pkg::STAT_W-1:0]; // RULE2
    end
    // write one to clear; an event in the same cycle wins
    st_nxt.stat = st_r.stat & ~(wrStat ? wb_dat_i[ccf_pkg::STAT_W-1:0] : ccf_pkg::STAT_RESET);
    st_nxt.stat = st_nxt.stat | evtVec; // RULE2
    st_nxt.irq = pending; // RULE2
    st_nxt.wake = idleMode & st_r.cfg[ccf_pkg::CFG_WAKE] & pending; // RULE12
    // low result on an enabled comparator zero asks for reset
    st_nxt.rstReq = st_r.cfg[ccf_pkg::CFG_RST0] & ana0.on & ~resVec[0]; // RULE13
    st_nxt.latch = resVec; // RULE14
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = {{(32-ccf_pkg::REG_W){1'b0}}, st_r.rdat};
  assign lowPower = {st_r.cfg[ccf_pkg::CFG_LP1], st_r.cfg[ccf_pkg::CFG_LP0]}; // RULE15
  assign latchOut = st_r.latch; // RULE14
  // the unlatched path bypasses all flops on purpose: it is the fast route to a pin
  assign asyncOut = cmpRaw & chOn; // RULE14
  assign irq = st_r.irq;
  assign wakeReq = st_r.wake;
  assign rstReq = st_r.rstReq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_ack_follows;
    take |=> st_r.ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack missing after strobe");

  property p_ack_one;
    st_r.ack |=> !st_r.ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held for two cycles");

  property p_rise_flag;
    evt0.rise |=> ctrl0[ccf_pkg::RISE_BIT] && st_r.stat[0];
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rising edge not flagged"); // RULE4

  property p_fall_flag;
    evt1.fall |=> ctrl1[ccf_pkg::FALL_BIT] && st_r.stat[3];
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("falling edge not flagged"); // RULE3

  property p_sticky;
    ctrl0[ccf_pkg::RISE_BIT] && !wrCtl[0] |=> ctrl0[ccf_pkg::RISE_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("rise flag cleared by hardware"); // RULE5

  property p_fall_sticky;
    ctrl1[ccf_pkg::FALL_BIT] && !wrCtl[1] |=> ctrl1[ccf_pkg::FALL_BIT];
  endproperty
  a_fall_sticky: assert property (p_fall_sticky) else $error("fall flag cleared by hardware"); // RULE5

  property p_edge_detect;
    !resVec[0] ##1 resVec[0] |-> evt0.rise && !evt0.fall;
  endproperty
  a_edge_detect: assert property (p_edge_detect) else $error("edge not detected"); // RULE16

  property p_result;
    rawSync[1] && chOn[1] |=> ctrl1[ccf_pkg::RES_BIT];
  endproperty
  a_result: assert property (p_result) else $error("result bit not tracking"); // RULE6

  property p_enable;
    wrCtl[1] |=> ana1.on == $past(wb_dat_i[ccf_pkg::EN_BIT]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable write not applied"); // RULE7

  property p_hyst_neg;
    wrCtl[0] |=> ana0.negMv == ccf_pkg::hyst_mv($past(wb_dat_i[1:0]));
  endproperty
  a_hyst_neg: assert property (p_hyst_neg) else $error("negative hysteresis wrong"); // RULE9

  property p_hyst_pos;
    wrCtl[0] |=> ana0.posMv == ccf_pkg::hyst_mv($past(wb_dat_i[3:2])) &&
      ctrl0[3:0] == $past(wb_dat_i[3:0]);
  endproperty
  a_hyst_pos: assert property (p_hyst_pos) else $error("positive hysteresis wrong"); // RULE10 RULE8

  property p_irq;
    pending |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised"); // RULE2

  property p_set_wins;
    evt0.rise && wrStat && wb_dat_i[0] |=> st_r.stat[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear"); // RULE2

  property p_wake;
    idleMode && st_r.cfg[ccf_pkg::CFG_WAKE] && pending |=> wakeReq;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from idle"); // RULE12

  property p_rst_src;
    st_r.cfg[ccf_pkg::CFG_RST0] && ana0.on && !resVec[0] |=> rstReq;
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("reset source not asserted"); // RULE13

  property p_latch;
    $changed(resVec) |=> latchOut == $past(resVec);
  endproperty
  a_latch: assert property (p_latch) else $error("latched output stale"); // RULE14

  property p_low_power;
    wrCfg |=> lowPower == $past(wb_dat_i[1:0]);
  endproperty
  a_low_power: assert property (p_low_power) else $error("response mode not applied"); // RULE15

  property p_irq_clear;
    !pending |=> !irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt without pending event"); // RULE2

  property p_rise_flag1;
    evt1.rise |=> ctrl1[ccf_pkg::RISE_BIT] && st_r.stat[2];
  endproperty
  a_rise_flag1: assert property (p_rise_flag1) else $error("rising edge one not flagged"); // RULE4

  property p_fall_flag0;
    evt0.fall |=> ctrl0[ccf_pkg::FALL_BIT] && st_r.stat[1];
  endproperty
  a_fall_flag0: assert property (p_fall_flag0) else $error("falling edge zero not flagged"); // RULE3

  property p_sticky1;
    ctrl1[ccf_pkg::RISE_BIT] && !wrCtl[1] |=> ctrl1[ccf_pkg::RISE_BIT];
  endproperty
  a_sticky1: assert property (p_sticky1) else $error("rise flag one cleared by hardware"); // RULE5

  property p_fall_sticky0;
    ctrl0[ccf_pkg::FALL_BIT] && !wrCtl[0] |=> ctrl0[ccf_pkg::FALL_BIT];
  endproperty
  a_fall_sticky0: assert property (p_fall_sticky0) else $error("fall flag zero cleared"); // RULE5

  property p_stat_sticky;
    st_r.stat[0] && !wrStat |=> st_r.stat[0];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost"); // RULE2

  property p_result_low;
    !(rawSync[0] && chOn[0]) |=> !ctrl0[ccf_pkg::RES_BIT];
  endproperty
  a_result_low: assert property (p_result_low) else $error("result bit stuck high"); // RULE6

  property p_enable0;
    wrCtl[0] |=> ana0.on == $past(wb_dat_i[ccf_pkg::EN_BIT]);
  endproperty
  a_enable0: assert property (p_enable0) else $error("enable zero write not applied"); // RULE7

  property p_hyst_neg1;
    wrCtl[1] |=> ana1.negMv == ccf_pkg::hyst_mv($past(wb_dat_i[1:0])) &&
      ctrl1[1:0] == $past(wb_dat_i[1:0]);
  endproperty
  a_hyst_neg1: assert property (p_hyst_neg1) else $error("negative hysteresis one wrong"); // RULE9 RULE8

  property p_hyst_pos1;
    wrCtl[1] |=> ana1.posMv == ccf_pkg::hyst_mv($past(wb_dat_i[3:2]));
  endproperty
  a_hyst_pos1: assert property (p_hyst_pos1) else $error("positive hysteresis one wrong"); // RULE10

  property p_edge_fall;
    resVec[1] ##1 !resVec[1] |-> evt1.fall && !evt1.rise;
  endproperty
  a_edge_fall: assert property (p_edge_fall) else $error("falling edge not detected"); // RULE16

  property p_no_edge;
    $stable(resVec[0]) |-> !evt0.rise && !evt0.fall;
  endproperty
  a_no_edge: assert property (p_no_edge) else $error("edge without result change"); // RULE16

  property p_wake_off;
    !idleMode |=> !wakeReq;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake outside idle"); // RULE12

  property p_rst_off;
    !st_r.cfg[ccf_pkg::CFG_RST0] |=> !rstReq;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("reset source while disabled"); // RULE13

  property p_cov_rise;
    evt0.rise ##1 ctrl0[ccf_pkg::RISE_BIT];
  endproperty
  c_cov_rise: cover property (p_cov_rise);

  property p_cov_irq;
    !irq ##1 irq;
  endproperty
  c_cov_irq: cover property (p_cov_irq);

  property p_cov_wake;
    idleMode ##1 wakeReq;
  endproperty
  c_cov_wake: cover property (p_cov_wake);

  property p_cov_rst;
    !rstReq ##1 rstReq;
  endproperty
  c_cov_rst: cover property (p_cov_rst);
endmodule // ccf_top

/* File: testbench/testbench.sv */
// self-checking bench for the comparator control block over classic wishbone
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [1:0] cmpRaw = 2'h0;
  logic idleMode = 1'b0;
  ccf_pkg::ccf_ana_s ana0;
  ccf_pkg::ccf_ana_s ana1;
  logic [1:0] lowPower;
  logic [1:0] latchOut;
  logic [1:0] asyncOut;
  logic irq;
  logic wakeReq;
  logic rstReq;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rdFull;
  logic [4:0] mvTab [4];
  logic [7:0] code;

  ccf_top DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmpRaw(cmpRaw), .idleMode(idleMode),
    .ana0(ana0), .ana1(ana1), .lowPower(lowPower), .latchOut(latchOut),
    .asyncOut(asyncOut), .irq(irq), .wakeReq(wakeReq), .rstReq(rstReq));

  always #2 clk = ~clk;

  task automatic final_report();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wbCycle(input logic we, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {2'b00, idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk("ack", 32'h1, {31'h0, wb_ack_o});
    rdFull = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wbCycle(1'b1, idx, d);
  endtask

  task automatic rdChk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    wbCycle(1'b0, idx, 8'h00);
    chk(name, {24'h000000, exp}, rdFull);
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic setRaw(input int ch, input logic v);
    @(posedge clk);
    cmpRaw[ch] <= v;
    waitCyc(6);
  endtask

  initial begin
    mvTab[0] = ccf_pkg::HYST_OFF_MV;
    mvTab[1] = ccf_pkg::HYST_5_MV;
    mvTab[2] = ccf_pkg::HYST_10_MV;
    mvTab[3] = ccf_pkg::HYST_20_MV;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdChk("ctrl0", ccf_pkg::CMP0_CTRL_IDX, 8'h00);
    rdChk("ctrl1", ccf_pkg::CMP1_CTRL_IDX, 8'h00);
    rdChk("cfg", ccf_pkg::CFG_IDX, 8'h00);
    rdChk("stat", ccf_pkg::IRQ_STAT_IDX, 8'h00);
    rdChk("mask", ccf_pkg::IRQ_MASK_IDX, 8'h00);
    chk("irq", 32'h0, {31'h0, irq});
    // every code in both fields; bit6 written high must not stick
    for (int c = 0; c < 4; c++) begin
      code = 8'h80 | 8'(c << 2) | 8'(3 - c);
      wr(ccf_pkg::CMP1_CTRL_IDX, code | 8'h40);
      waitCyc(2);
      chk("ana1.on", 32'h1, {31'h0, ana1.on});
      chk("ana1.posMv", {27'h0, mvTab[c]}, {27'h0, ana1.posMv});
      chk("ana1.negMv", {27'h0, mvTab[3 - c]}, {27'h0, ana1.negMv});
      rdChk("ctrl1 hyst", ccf_pkg::CMP1_CTRL_IDX, code);
    end
    chk("ana0.on", 32'h0, {31'h0, ana0.on});
    wr(ccf_pkg::CMP1_CTRL_IDX, 8'h8C);
    setRaw(1, 1'b1);
    rdChk("ctrl1 rise", ccf_pkg::CMP1_CTRL_IDX, 8'hEC);
    chk("asyncOut", 32'h2, {30'h0, asyncOut});
    chk("latchOut", 32'h2, {30'h0, latchOut});
    rdChk("stat rise", ccf_pkg::IRQ_STAT_IDX, 8'h04);
    rdChk("ctrl0 alone", ccf_pkg::CMP0_CTRL_IDX, 8'h00);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ccf_pkg::IRQ_MASK_IDX, 8'h04);
    waitCyc(2);
    chk("irq rise", 32'h1, {31'h0, irq});
    wr(ccf_pkg::IRQ_STAT_IDX, 8'h04);
    waitCyc(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdChk("flag sticky", ccf_pkg::CMP1_CTRL_IDX, 8'hEC);
    setRaw(1, 1'b0);
    rdChk("ctrl1 fall", ccf_pkg::CMP1_CTRL_IDX, 8'hBC);
    rdChk("stat fall", ccf_pkg::IRQ_STAT_IDX, 8'h08);
    chk("irq fall masked", 32'h0, {31'h0, irq});
    wr(ccf_pkg::IRQ_MASK_IDX, 8'h08);
    waitCyc(2);
    chk("irq fall", 32'h1, {31'h0, irq});
    @(posedge clk);
    idleMode <= 1'b1;
    wr(ccf_pkg::CFG_IDX, 8'h08);
    waitCyc(2);
    chk("wakeReq", 32'h1, {31'h0, wakeReq});
    @(posedge clk);
    idleMode <= 1'b0;
    waitCyc(2);
    chk("wakeReq idle off", 32'h0, {31'h0, wakeReq});
    wr(ccf_pkg::IRQ_STAT_IDX, 8'h0F);
    wr(ccf_pkg::CMP1_CTRL_IDX, 8'h8C);
    rdChk("flags cleared", ccf_pkg::CMP1_CTRL_IDX, 8'h8C);
    waitCyc(2);
    chk("irq idle", 32'h0, {31'h0, irq});
    // low-power select and reset source on comparator zero
    wr(ccf_pkg::CFG_IDX, 8'h07);
    waitCyc(2);
    chk("lowPower", 32'h3, {30'h0, lowPower});
    chk("rstReq off", 32'h0, {31'h0, rstReq});
    wr(ccf_pkg::CMP0_CTRL_IDX, 8'h80);
    waitCyc(3);
    chk("rstReq low", 32'h1, {31'h0, rstReq});
    setRaw(0, 1'b1);
    chk("rstReq high", 32'h0, {31'h0, rstReq});
    rdChk("ctrl0 rise", ccf_pkg::CMP0_CTRL_IDX, 8'hE0);
    chk("asyncOut0", 32'h1, {30'h0, asyncOut});
    wr(ccf_pkg::CFG_IDX, 8'h01);
    waitCyc(2);
    chk("lowPower0", 32'h1, {30'h0, lowPower});
    // turning off with the result high reads as one falling edge
    wr(ccf_pkg::CMP0_CTRL_IDX, 8'h20);
    waitCyc(4);
    rdChk("ctrl0 off", ccf_pkg::CMP0_CTRL_IDX, 8'h30);
    chk("asyncOut off", 32'h0, {30'h0, asyncOut});
    rdChk("stat ch0", ccf_pkg::IRQ_STAT_IDX, 8'h03);
    wr(8'h10, 8'hFF);
    rdChk("unmapped", 8'h10, 8'h00);
    rdChk("ctrl0 kept", ccf_pkg::CMP0_CTRL_IDX, 8'h30);
    final_report();
  end
endmodule // testbench
